// ==== rtl/sos_pkg.sv ====
/*
  sos_pkg: constants and types for the status output selector.
  assumes: 40 MHz control clock, Avalon-MM register access, 32-bit bus.
*/
package sos_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [5:0] ADDR_AO_SRC     = 6'h00;
  localparam logic [5:0] ADDR_DO_FUNC    = 6'h04;
  localparam logic [5:0] ADDR_POLARITY   = 6'h08;
  localparam logic [5:0] ADDR_DELAY      = 6'h0c;
  localparam logic [5:0] ADDR_PWR_THR    = 6'h10;
  localparam logic [5:0] ADDR_RUN_THR    = 6'h14;
  localparam logic [5:0] ADDR_TIMER_CFG  = 6'h18;
  localparam logic [5:0] ADDR_AIN_LIMITS = 6'h1c;
  localparam logic [5:0] ADDR_HS_THR     = 6'h20;
  localparam logic [5:0] ADDR_STATUS     = 6'h24;
  localparam logic [5:0] ADDR_AO_VALUE   = 6'h28;
  localparam logic [5:0] ADDR_AO_UNIT    = 6'h2c;

  // ------------------------------------------------------------------
  // reset values and widths
  // ------------------------------------------------------------------
  localparam logic [15:0] AO_SRC_RST   = 16'h0000;
  localparam logic [5:0]  DO_FUNC_RST  = 6'h00;
  localparam logic [15:0] DELAY_RST    = 16'h0000;
  localparam logic [31:0] THR_RST      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
  localparam int          AO_W         = 16;
  localparam logic [15:0] AO_FULL      = 16'hffff;
  localparam logic [16:0] AO_FULL_X2   = 17'h1_fffe;

  // ------------------------------------------------------------------
  // timing: delay unit of 0.1 s
  // ------------------------------------------------------------------
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          DELAY_TICK_MS = 100;
  localparam int          DELAY_TICK_CYC = CLK_HZ / 1000 * DELAY_TICK_MS;
  localparam logic [15:0] DELAY_MAX     = 16'h8ca0;

  // ------------------------------------------------------------------
  // digital output function codes
  // ------------------------------------------------------------------
  localparam logic [5:0] FN_ZERO_SPEED2 = 6'h17;
  localparam logic [5:0] FN_PWR_TIME    = 6'h18;
  localparam logic [5:0] FN_TIMER       = 6'h1e;
  localparam logic [5:0] FN_AIN_OVR     = 6'h1f;
  localparam logic [5:0] FN_LOAD_LOSS   = 6'h20;
  localparam logic [5:0] FN_REVERSE     = 6'h21;
  localparam logic [5:0] FN_HEATSINK    = 6'h23;
  localparam logic [5:0] FN_LOW_LIMIT   = 6'h25;
  localparam logic [5:0] FN_ALARM       = 6'h26;
  localparam logic [5:0] FN_MOTOR_OT    = 6'h27;
  localparam logic [5:0] FN_RUN_TIME    = 6'h28;
  localparam logic [5:0] FN_FAULT_COAST = 6'h29;

  // ------------------------------------------------------------------
  // analog source codes
  // ------------------------------------------------------------------
  localparam logic [4:0] SRC_RUN_FREQ  = 5'h00;
  localparam logic [4:0] SRC_SET_FREQ  = 5'h01;
  localparam logic [4:0] SRC_CURRENT   = 5'h02;
  localparam logic [4:0] SRC_TORQUE    = 5'h03;
  localparam logic [4:0] SRC_POWER     = 5'h04;
  localparam logic [4:0] SRC_VOLTAGE   = 5'h05;
  localparam logic [4:0] SRC_PULSE     = 5'h06;
  localparam logic [4:0] SRC_AIN1      = 5'h07;
  localparam logic [4:0] SRC_LENGTH    = 5'h0a;
  localparam logic [4:0] SRC_COUNT     = 5'h0b;
  localparam logic [4:0] SRC_COMM      = 5'h0c;
  localparam logic [4:0] SRC_SPEED     = 5'h0d;
  localparam logic [4:0] SRC_AMPS      = 5'h0e;
  localparam logic [4:0] SRC_VOLTS     = 5'h0f;
  localparam logic [4:0] SRC_TORQ_SIGN = 5'h10;

  // fixed full scales for sources 14..15 (0.1 units), pulse in 0.01 kHz
  localparam logic [15:0] AMPS_FS   = 16'h2710;
  localparam logic [15:0] VOLTS_FS  = 16'h2710;
  localparam logic [15:0] PULSE_MIN = 16'h0001;
  localparam logic [15:0] PULSE_MAX = 16'h2710;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        running;
    logic        reverse;
    logic        at_low_limit;
    logic        load_loss;
    logic        alarm_continue;
    logic        motor_overtemp;
    logic        fault_coast;
    logic        undervoltage;
    logic [15:0] out_freq;
    logic [31:0] poweron_time_monitor;
    logic [31:0] run_time;
    logic [15:0] heatsink_temp;
    logic [15:0] analog_input_one;
  } sos_status_t;

  typedef struct packed {
    logic [15:0] run_freq;
    logic [15:0] set_freq;
    logic [15:0] max_freq;
    logic [15:0] current;
    logic [15:0] rated_current;
    logic [15:0] torque;
    logic [15:0] rated_torque;
    logic [15:0] power;
    logic [15:0] rated_power;
    logic [15:0] voltage;
    logic [15:0] rated_voltage;
    logic [15:0] pulse_freq;
    logic [15:0] ain_full;
    logic [15:0] length;
    logic [15:0] max_length;
    logic [15:0] count;
    logic [15:0] max_count;
    logic [15:0] comm_set;
    logic [15:0] speed;
    logic [15:0] max_speed;
  } sos_meas_t;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01
  } sos_dly_state_t;

endpackage : sos_pkg

// ==== rtl/sos_scaler.sv ====
/*
  sos_scaler: registered linear scaler, value * full_code / span.
  assumes: same clock and enable as the selector; one result per cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module sos_scaler #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  // operands
  input  wire logic [W-1:0] value_in,
  input  wire logic [W:0]   span_in,
  input  wire logic         zero_in,
  // result
  output logic [W-1:0]      scaled_out
);

  logic [W-1:0] scaled_ff;
  logic [2*W:0] prod;
  logic [2*W:0] quot;

  // ------------------------------------------------------------------
  // clamp and divide
  // ------------------------------------------------------------------
  always_comb begin
    prod = {1'b0, value_in, {W{1'b0}}} - {{(W+1){1'b0}}, value_in};
    quot = (span_in == '0) ? '0 : prod / {{W{1'b0}}, span_in};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scaled_ff <= '0;
    end else if (ce_in) begin
      if (zero_in) begin
        scaled_ff <= '0;
      end else if (quot > {{(W+1){1'b0}}, {W{1'b1}}}) begin
        scaled_ff <= {W{1'b1}};
      end else begin
        scaled_ff <= quot[W-1:0];
      end
    end
  end

  assign scaled_out = scaled_ff;

endmodule // sos_scaler

`default_nettype wire

// ==== rtl/sos_selector.sv ====
/*
  sos_selector: routes a drive status condition to the relay terminal and
  scales a selected quantity onto the analog output span.
  assumes: status and measurement inputs come from logic on SYS_CLK_IN;
  Avalon-MM slave with waitrequest for the registers.
*/
`timescale 1ns/1ps
`default_nettype none

module sos_selector #(
  parameter int DELAY_TICK = sos_pkg::DELAY_TICK_CYC
) (
  // clock and reset
  input  wire logic                SYS_CLK_IN,
  input  wire logic                RESET_IN,
  input  wire logic                CLK_EN_IN,
  // avalon-mm slave
  input  wire logic [5:0]          AVS_ADDRESS_IN,
  input  wire logic                AVS_READ_IN,
  input  wire logic                AVS_WRITE_IN,
  input  wire logic [31:0]         AVS_WRITEDATA_IN,
  input  wire logic [3:0]          AVS_BYTEENABLE_IN,
  output logic [31:0]              AVS_READDATA_OUT,
  output logic                     AVS_WAITREQUEST_OUT,
  // drive status and measurements
  input  wire sos_pkg::sos_status_t STATUS_IN,
  input  wire sos_pkg::sos_meas_t   MEAS_IN,
  // terminal outputs
  output logic                     RELAY_OUTPUT_ONE_OUT,
  output logic [15:0]              ANALOG_OUTPUT_ONE_OUT
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [15:0] ao_src_ff;
  logic [5:0]  do_func_ff;
  logic        polarity_ff;
  logic [15:0] delay_ff;
  logic [31:0] pwr_thr_ff;
  logic [31:0] run_thr_ff;
  logic        timer_en_ff;
  logic [31:0] timer_val_ff;
  logic [15:0] ain_lo_ff;
  logic [15:0] ain_hi_ff;
  logic [15:0] hs_thr_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  logic        cond;
  logic        cond_ff;
  logic        relay_ff;
  logic        pending_ff;
  logic [15:0] ticks_ff;
  logic [31:0] cyc_ff;
  logic [15:0] ao_ff;
  sos_pkg::sos_dly_state_t dly_ff;

  logic        req;
  logic [15:0] sel_val;
  logic [16:0] sel_span;
  logic        sel_zero;
  logic [15:0] scaled;
  logic [18:0] torq_ofs;

  // ------------------------------------------------------------------
  // byte-lane merge
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // twice a 16-bit scale, as a 17-bit span
  function automatic logic [16:0] twice(input logic [15:0] v);
    return {v, 1'b0};
  endfunction

  // ------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second
  // ------------------------------------------------------------------
  assign req                 = (AVS_READ_IN | AVS_WRITE_IN) & CLK_EN_IN;
  assign AVS_WAITREQUEST_OUT = ~(ack_ff & CLK_EN_IN);
  assign AVS_READDATA_OUT    = rdata_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ack_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ao_src_ff    <= sos_pkg::AO_SRC_RST;
      do_func_ff   <= sos_pkg::DO_FUNC_RST;
      polarity_ff  <= 1'b0;
      delay_ff     <= sos_pkg::DELAY_RST;
      pwr_thr_ff   <= sos_pkg::THR_RST;
      run_thr_ff   <= sos_pkg::THR_RST;
      timer_en_ff  <= 1'b0;
      timer_val_ff <= sos_pkg::THR_RST;
      ain_lo_ff    <= 16'h0000;
      ain_hi_ff    <= 16'hffff;
      hs_thr_ff    <= 16'hffff;
    end else if (CLK_EN_IN && AVS_WRITE_IN && ack_ff) begin
      unique case (AVS_ADDRESS_IN)
        sos_pkg::ADDR_AO_SRC: begin
          ao_src_ff <= 16'(merge({16'h0000, ao_src_ff}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
        end
        sos_pkg::ADDR_DO_FUNC: begin
          do_func_ff <= 6'(merge({26'h0, do_func_ff}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
        end
        sos_pkg::ADDR_POLARITY: begin
          polarity_ff <= 1'(merge({31'h0, polarity_ff}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
        end
        sos_pkg::ADDR_DELAY: begin
          delay_ff <= 16'(merge({16'h0000, delay_ff}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
        end
        sos_pkg::ADDR_PWR_THR: begin
          pwr_thr_ff <= merge(pwr_thr_ff, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
        sos_pkg::ADDR_RUN_THR: begin
          run_thr_ff <= merge(run_thr_ff, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
        sos_pkg::ADDR_TIMER_CFG: begin
          {timer_en_ff, timer_val_ff[30:0]} <= merge({timer_en_ff, timer_val_ff[30:0]},
                                                     AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
        sos_pkg::ADDR_AIN_LIMITS: begin
          {ain_hi_ff, ain_lo_ff} <= merge({ain_hi_ff, ain_lo_ff}, AVS_WRITEDATA_IN,
                                          AVS_BYTEENABLE_IN);
        end
        sos_pkg::ADDR_HS_THR: begin
          hs_thr_ff <= 16'(merge({16'h0000, hs_thr_ff}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      rdata_ff <= sos_pkg::UNMAPPED_RD;
    end else if (CLK_EN_IN && req && !ack_ff) begin
      unique case (AVS_ADDRESS_IN)
        sos_pkg::ADDR_AO_SRC:     rdata_ff <= {16'h0000, ao_src_ff};
        sos_pkg::ADDR_DO_FUNC:    rdata_ff <= {26'h0, do_func_ff};
        sos_pkg::ADDR_POLARITY:   rdata_ff <= {31'h0, polarity_ff};
        sos_pkg::ADDR_DELAY:      rdata_ff <= {16'h0000, delay_ff};
        sos_pkg::ADDR_PWR_THR:    rdata_ff <= pwr_thr_ff;
        sos_pkg::ADDR_RUN_THR:    rdata_ff <= run_thr_ff;
        sos_pkg::ADDR_TIMER_CFG:  rdata_ff <= {timer_en_ff, timer_val_ff[30:0]};
        sos_pkg::ADDR_AIN_LIMITS: rdata_ff <= {ain_hi_ff, ain_lo_ff};
        sos_pkg::ADDR_HS_THR:     rdata_ff <= {16'h0000, hs_thr_ff};
        sos_pkg::ADDR_STATUS:     rdata_ff <= {29'h0, pending_ff, cond_ff, relay_ff};
        sos_pkg::ADDR_AO_VALUE:   rdata_ff <= {16'h0000, ao_ff};
        default:                  rdata_ff <= sos_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // condition selection, evaluated every cycle
  // ------------------------------------------------------------------
  always_comb begin
    cond = 1'b0;
    unique case (do_func_ff)
      sos_pkg::FN_ZERO_SPEED2: cond = (STATUS_IN.out_freq == 16'h0000);
      sos_pkg::FN_PWR_TIME:    cond = (STATUS_IN.poweron_time_monitor > pwr_thr_ff);
      sos_pkg::FN_TIMER:       cond = timer_en_ff & STATUS_IN.running &
                                      (STATUS_IN.run_time >= timer_val_ff);
      sos_pkg::FN_AIN_OVR:     cond = (STATUS_IN.analog_input_one > ain_hi_ff) |
                                      (STATUS_IN.analog_input_one < ain_lo_ff);
      sos_pkg::FN_LOAD_LOSS:   cond = STATUS_IN.load_loss;
      sos_pkg::FN_REVERSE:     cond = STATUS_IN.running & STATUS_IN.reverse;
      sos_pkg::FN_HEATSINK:    cond = (STATUS_IN.heatsink_temp >= hs_thr_ff);
      sos_pkg::FN_LOW_LIMIT:   cond = STATUS_IN.at_low_limit | ~STATUS_IN.running;
      sos_pkg::FN_ALARM:       cond = STATUS_IN.alarm_continue;
      sos_pkg::FN_MOTOR_OT:    cond = STATUS_IN.motor_overtemp;
      sos_pkg::FN_RUN_TIME:    cond = STATUS_IN.running &
                                      (STATUS_IN.run_time > run_thr_ff);
      sos_pkg::FN_FAULT_COAST: cond = STATUS_IN.fault_coast &
                                      ~STATUS_IN.undervoltage;
      default:                 cond = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cond_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      cond_ff <= cond;
    end
  end

  // ------------------------------------------------------------------
  // output delay in 0.1 s ticks
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      dly_ff     <= sos_pkg::DLY_IDLE;
      relay_ff   <= 1'b0;
      pending_ff <= 1'b0;
      ticks_ff   <= 16'h0000;
      cyc_ff     <= 32'h0000_0000;
    end else if (CLK_EN_IN) begin
      unique case (dly_ff)
        sos_pkg::DLY_IDLE: begin
          if (cond_ff != relay_ff) begin
            if (delay_ff == 16'h0000) begin
              relay_ff <= cond_ff;
            end else begin
              dly_ff     <= sos_pkg::DLY_WAIT;
              pending_ff <= 1'b1;
              ticks_ff   <= 16'h0000;
              cyc_ff     <= 32'h0000_0000;
            end
          end
        end
        sos_pkg::DLY_WAIT: begin
          if (cond_ff == relay_ff) begin
            dly_ff     <= sos_pkg::DLY_IDLE;
            pending_ff <= 1'b0;
          end else if (cyc_ff == 32'(DELAY_TICK - 1)) begin
            cyc_ff <= 32'h0000_0000;
            if (ticks_ff + 16'h0001 >= delay_ff || ticks_ff >= sos_pkg::DELAY_MAX) begin
              relay_ff   <= cond_ff;
              dly_ff     <= sos_pkg::DLY_IDLE;
              pending_ff <= 1'b0;
            end else begin
              ticks_ff <= ticks_ff + 16'h0001;
            end
          end else begin
            cyc_ff <= cyc_ff + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  assign RELAY_OUTPUT_ONE_OUT = relay_ff ^ polarity_ff;

  // ------------------------------------------------------------------
  // analog source selection and full scale
  // ------------------------------------------------------------------
  always_comb begin
    sel_val  = 16'h0000;
    sel_span = 17'h0_0001;
    sel_zero = 1'b0;
    torq_ofs = {{3{MEAS_IN.torque[15]}}, MEAS_IN.torque} + {2'b00, MEAS_IN.rated_torque, 1'b0};
    unique case (ao_src_ff[4:0])
      sos_pkg::SRC_RUN_FREQ: begin
        sel_val = MEAS_IN.run_freq; sel_span = {1'b0, MEAS_IN.max_freq};
      end
      sos_pkg::SRC_SET_FREQ: begin
        sel_val = MEAS_IN.set_freq; sel_span = {1'b0, MEAS_IN.max_freq};
      end
      sos_pkg::SRC_CURRENT: begin
        sel_val = MEAS_IN.current; sel_span = twice(MEAS_IN.rated_current);
      end
      sos_pkg::SRC_TORQUE: begin
        sel_val  = MEAS_IN.torque[15] ? 16'(-MEAS_IN.torque) : MEAS_IN.torque;
        sel_span = twice(MEAS_IN.rated_torque);
      end
      sos_pkg::SRC_POWER: begin
        sel_val = MEAS_IN.power; sel_span = {1'b0, MEAS_IN.rated_power};
      end
      sos_pkg::SRC_VOLTAGE: begin
        sel_val  = MEAS_IN.voltage;
        sel_span = 17'((({1'b0, MEAS_IN.rated_voltage} * 6) / 5));
      end
      sos_pkg::SRC_PULSE: begin
        sel_val  = (MEAS_IN.pulse_freq < sos_pkg::PULSE_MIN) ? 16'h0000 :
                   MEAS_IN.pulse_freq - sos_pkg::PULSE_MIN;
        sel_span = {1'b0, sos_pkg::PULSE_MAX - sos_pkg::PULSE_MIN};
      end
      sos_pkg::SRC_AIN1: begin
        sel_val = MEAS_IN.ain_full; sel_span = {1'b0, sos_pkg::AO_FULL};
      end
      sos_pkg::SRC_LENGTH: begin
        sel_val = MEAS_IN.length; sel_span = {1'b0, MEAS_IN.max_length};
      end
      sos_pkg::SRC_COUNT: begin
        sel_val = MEAS_IN.count; sel_span = {1'b0, MEAS_IN.max_count};
      end
      sos_pkg::SRC_COMM: begin
        sel_val = MEAS_IN.comm_set; sel_span = {1'b0, sos_pkg::AO_FULL};
      end
      sos_pkg::SRC_SPEED: begin
        sel_val = MEAS_IN.speed; sel_span = {1'b0, MEAS_IN.max_speed};
      end
      sos_pkg::SRC_AMPS: begin
        sel_val = MEAS_IN.current; sel_span = {1'b0, sos_pkg::AMPS_FS};
      end
      sos_pkg::SRC_VOLTS: begin
        sel_val = MEAS_IN.voltage; sel_span = {1'b0, sos_pkg::VOLTS_FS};
      end
      sos_pkg::SRC_TORQ_SIGN: begin
        sel_val  = torq_ofs[18] ? 16'h0000 :
                   (torq_ofs > {1'b0, MEAS_IN.rated_torque, 2'b00}) ? MEAS_IN.rated_torque :
                   torq_ofs[17:2];
        sel_span = {1'b0, MEAS_IN.rated_torque};
      end
      default: begin
        sel_zero = 1'b1;
      end
    endcase
    if (ao_src_ff[15:5] != 11'h000) begin
      sel_zero = 1'b1;
    end
  end

  sos_scaler #(
    .W (sos_pkg::AO_W)
  ) u_scaler (
    .clk_in     (SYS_CLK_IN),
    .rst_in     (RESET_IN),
    .ce_in      (CLK_EN_IN),
    .value_in   (sel_val),
    .span_in    (sel_span),
    .zero_in    (sel_zero),
    .scaled_out (scaled)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ao_ff <= 16'h0000;
    end else if (CLK_EN_IN) begin
      ao_ff <= scaled;
    end
  end

  assign ANALOG_OUTPUT_ONE_OUT = ao_ff;

endmodule // sos_selector

`default_nettype wire

// ==== verif/sos_selector_sva.sv ====
/* sos_selector_chk: port assertions for the selector.
   assumes: bound into sos_selector; writes use all byte lanes. */
`timescale 1ns/1ps
`default_nettype none
module sos_selector_chk (
  // clock and bus
  input wire logic                 SYS_CLK_IN,
  input wire logic                 RESET_IN,
  input wire logic                 CLK_EN_IN,
  input wire logic [5:0]           AVS_ADDRESS_IN,
  input wire logic                 AVS_WRITE_IN,
  input wire logic [31:0]          AVS_WRITEDATA_IN,
  input wire logic                 AVS_WAITREQUEST_OUT,
  // drive side
  input wire sos_pkg::sos_status_t STATUS_IN,
  input wire sos_pkg::sos_meas_t   MEAS_IN,
  input wire logic                 RELAY_OUTPUT_ONE_OUT,
  input wire logic [15:0]          ANALOG_OUTPUT_ONE_OUT
);
  logic [5:0]  fn_ff;
  logic [15:0] src_ff;
  logic [1:0]  q_ff;
  logic        pol_ff, d0_ff, ok, wa, rsv;
  assign wa  = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && CLK_EN_IN;
  assign ok  = q_ff == 2'h3 && CLK_EN_IN && d0_ff;
  assign rsv = src_ff == 16'h8 || src_ff == 16'h9 || src_ff > 16'h10;
  // shadow of written config, quiet count since last write or cycle with CLK_EN_IN low
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      {fn_ff, src_ff, q_ff, pol_ff, d0_ff} <= {24'h0, 1'b0, 1'b1};
    end else begin
      q_ff <= (wa || !CLK_EN_IN) ? 2'h0 : q_ff + {1'b0, q_ff != 2'h3};
      if (wa && AVS_ADDRESS_IN == sos_pkg::ADDR_DO_FUNC) fn_ff <= AVS_WRITEDATA_IN[5:0];
      if (wa && AVS_ADDRESS_IN == sos_pkg::ADDR_AO_SRC) src_ff <= AVS_WRITEDATA_IN[15:0];
      if (wa && AVS_ADDRESS_IN == sos_pkg::ADDR_POLARITY) pol_ff <= AVS_WRITEDATA_IN[0];
      if (wa && AVS_ADDRESS_IN == sos_pkg::ADDR_DELAY) d0_ff <= AVS_WRITEDATA_IN[15:0] == 16'h0;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_rst; disable iff (1'b0) RESET_IN && CLK_EN_IN |=> !RELAY_OUTPUT_ONE_OUT &&
    ANALOG_OUTPUT_ONE_OUT == 16'h0 && AVS_WAITREQUEST_OUT; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_zero; (ok && fn_ff == 6'h17 && STATUS_IN.out_freq == 16'h0) ##2 ok |->
    RELAY_OUTPUT_ONE_OUT != pol_ff; endproperty
  a_zero: assert property (p_zero) else $error("zero speed not shown");
  property p_low; (ok && fn_ff == 6'h25 && !STATUS_IN.running) ##2 ok |->
    RELAY_OUTPUT_ONE_OUT != pol_ff; endproperty
  a_low: assert property (p_low) else $error("stopped not shown");
  property p_loss; (ok && fn_ff == 6'h20) ##2 ok |->
    RELAY_OUTPUT_ONE_OUT == ($past(STATUS_IN.load_loss, 2) ^ pol_ff); endproperty
  a_loss: assert property (p_loss) else $error("load loss relay wrong");
  property p_rev; (ok && fn_ff == 6'h21 && STATUS_IN.reverse && STATUS_IN.running) ##2 ok |->
    RELAY_OUTPUT_ONE_OUT != pol_ff; endproperty
  a_rev: assert property (p_rev) else $error("reverse not shown");
  property p_uv; (ok && fn_ff == 6'h29 && STATUS_IN.undervoltage) ##2 ok |->
    RELAY_OUTPUT_ONE_OUT == pol_ff; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage gave fault");
  property p_rsv; (ok && rsv) ##2 ok |-> ANALOG_OUTPUT_ONE_OUT == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source not zero");
  property p_full; (ok && src_ff == 16'h2 && {1'b0, MEAS_IN.current} ==
    {MEAS_IN.rated_current, 1'b0}) ##2 ok |-> ANALOG_OUTPUT_ONE_OUT == 16'hffff; endproperty
  a_full: assert property (p_full) else $error("current full scale wrong");
  property p_zsc; (ok && src_ff == 16'h0 && MEAS_IN.run_freq == 16'h0) ##2 ok |->
    ANALOG_OUTPUT_ONE_OUT == 16'h0; endproperty
  a_zsc: assert property (p_zsc) else $error("zero frequency not zero");
  c_zero: cover property (ok && fn_ff == 6'h17 && STATUS_IN.out_freq == 16'h0);
  c_rsv: cover property (ok && rsv);
  c_full: cover property (ANALOG_OUTPUT_ONE_OUT == 16'hffff);
endmodule // sos_selector_chk
bind sos_selector sos_selector_chk u_chk (.SYS_CLK_IN, .RESET_IN, .CLK_EN_IN, .AVS_ADDRESS_IN,
  .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_WAITREQUEST_OUT, .STATUS_IN, .MEAS_IN,
  .RELAY_OUTPUT_ONE_OUT, .ANALOG_OUTPUT_ONE_OUT);
`default_nettype wire

// ==== verif/tb.sv ====
/* tb: self-checking bench for sos_selector.
   assumes: delay tick shortened to 4 clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, relay;
  logic [5:0]           adr = '0;
  logic [31:0]          wd = '0, rdat, q;
  logic [15:0]          ao;
  sos_pkg::sos_status_t st = '0;
  sos_pkg::sos_meas_t   ms = '0;
  int                   num_errors = 0, checks_done = 0, cyc = 0;
  always #12.5 clk = ~clk;
  sos_selector #(.DELAY_TICK(4)) u_dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt),
    .STATUS_IN(st), .MEAS_IN(ms), .RELAY_OUTPUT_ONE_OUT(relay), .ANALOG_OUTPUT_ONE_OUT(ao));
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic set_cond(input logic [5:0] c, input logic on);
    sos_pkg::sos_status_t s;
    s = '0;
    s.running = 1'b1;
    s.out_freq = on || c != 6'h17 ? 16'h5 : 16'h0;
    if (c == 6'h17) s.out_freq = on ? 16'h0 : 16'h5;
    case (c)
      6'h18: s.poweron_time_monitor = on ? 32'hb : 32'ha;
      6'h1e: s.run_time = on ? 32'h14 : 32'h13;
      6'h1f: s.analog_input_one = on ? 16'h9001 : 16'h9000;
      6'h20: s.load_loss = on;
      6'h21: s.reverse = on;
      6'h23: s.heatsink_temp = on ? 16'h32 : 16'h31;
      6'h25: s.running = !on;
      6'h26: s.alarm_continue = on;
      6'h27: s.motor_overtemp = on;
      6'h28: s.run_time = on ? 32'h1f : 32'h1e;
      6'h29: {s.fault_coast, s.undervoltage} = {1'b1, !on};
      default: ;
    endcase
    @(posedge clk);
    st <= s;
  endtask
  task automatic t_regs;
    bus(0, sos_pkg::ADDR_AO_SRC, '0);
    chk(q, 32'h0);
    bus(1, sos_pkg::ADDR_AO_SRC, 32'h10);
    bus(0, sos_pkg::ADDR_AO_SRC, '0);
    chk(q, 32'h10);
    bus(0, 6'h3c, '0);
    chk(q, sos_pkg::UNMAPPED_RD);
  endtask
  task automatic t_codes;
    logic [5:0] c [12] = '{6'h17, 6'h18, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h23, 6'h25, 6'h26,
                           6'h27, 6'h28, 6'h29};
    bus(1, sos_pkg::ADDR_PWR_THR, 32'ha);
    bus(1, sos_pkg::ADDR_RUN_THR, 32'h1e);
    bus(1, sos_pkg::ADDR_TIMER_CFG, 32'h8000_0014);
    bus(1, sos_pkg::ADDR_AIN_LIMITS, 32'h9000_1000);
    bus(1, sos_pkg::ADDR_HS_THR, 32'h32);
    foreach (c[i]) begin
      bus(1, sos_pkg::ADDR_DO_FUNC, {26'h0, c[i]});
      for (int on = 1; on >= 0; on--) begin
        set_cond(c[i], on[0]);
        repeat (4) @(posedge clk);
        chk({31'h0, relay}, {31'h0, on[0]});
      end
    end
  endtask
  task automatic t_pol;
    bus(1, sos_pkg::ADDR_DO_FUNC, 32'h20);
    bus(1, sos_pkg::ADDR_POLARITY, 32'h1);
    set_cond(6'h20, 1'b1);
    repeat (4) @(posedge clk);
    chk({31'h0, relay}, 32'h0);
    set_cond(6'h20, 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, relay}, 32'h1);
    bus(1, sos_pkg::ADDR_POLARITY, 32'h0);
  endtask
  task automatic t_delay;
    bus(1, sos_pkg::ADDR_DELAY, 32'h2);
    set_cond(6'h20, 1'b1);
    repeat (3) @(posedge clk);
    set_cond(6'h20, 1'b0);
    repeat (20) @(posedge clk);
    chk({31'h0, relay}, 32'h0);
    set_cond(6'h20, 1'b1);
    repeat (5) @(posedge clk);
    chk({31'h0, relay}, 32'h0);
    repeat (15) @(posedge clk);
    chk({31'h0, relay}, 32'h1);
    bus(1, sos_pkg::ADDR_DELAY, 32'h0);
  endtask
  task automatic t_analog;
    logic [4:0] s [18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0a,
                           5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h0f, 5'h08, 5'h09, 5'h11};
    foreach (s[i]) begin
      bus(1, sos_pkg::ADDR_AO_SRC, {27'h0, s[i]});
      repeat (4) @(posedge clk);
      chk({16'h0, ao}, (i < 14) ? 32'hffff : (i == 14) ? 32'h1eb8 : 32'h0);
    end
    ms.run_freq <= 16'h0;
    bus(1, sos_pkg::ADDR_AO_SRC, 32'h0);
    repeat (7) @(posedge clk);
    chk({16'h0, ao}, 32'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    ms = '{run_freq:16'h64, set_freq:16'h64, max_freq:16'h64, current:16'h2710,
           rated_current:16'h1388, torque:16'hc8, rated_torque:16'h64, power:16'h64,
           rated_power:16'h64, voltage:16'h4b0, rated_voltage:16'h3e8, length:16'h32,
           max_length:16'h32, count:16'h32, max_count:16'h32, speed:16'h64,
           max_speed:16'h64, pulse_freq:16'h2710, ain_full:16'hffff, comm_set:16'hffff};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_codes();
    t_pol();
    t_delay();
    t_analog();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
